// [hw/amsc_top.sv]
// Purpose: adapter detect, power sequencing, clock and rail monitor
// Assumes: one 250 MHz clock, synchronous active-low reset
// Notes:   status snapshots are refreshed at the 40 MHz rate
//
// Functional notes
// - report 32-bit code read from the fitted adapter
// - report fixed 32-bit required code set by the loaded design
// - adapter usable only when fitted code equals required code
// - pin buffers on only when present, powered and compatible
// - supply on only when present and compatible; flag set at switch-on, before power-good
// - adapter drives power-good; device reports its level
// - presence flag follows physical attachment
// - flag shows the adapter id eeprom supply is on
// - report board temperature in whole degrees Celsius
// - temperature sampled at the 40 MHz status rate
// - pll uses backplane reference, else onboard oscillator
// - on lock loss from backplane, relock to onboard oscillator
// - lost-lock flag set if pll ever left lock since load
// - report low rail power in 10 mW counts
// - report high rail power in 10 mW counts
// - shut down above 9.7 W, 35.5 W, or 37.75 W combined
// - host command powers adapter on or off, only while inserted
// - status query answers whether or not an adapter is inserted
// - on code mismatch flag it and keep power and pins off
// - presence, power-good, temperature and power sampled at the 40 MHz rate
//
// The strobed register port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "amsc_regs.svh"

module amsc_top
   import amsc_pkg::*;
#(
   parameter logic [31:0] REQ_CODE      = `AMSC_REQ_CODE_DEF,
   parameter int          TEMP_WAIT_CYC = `AMSC_TEMP_WAIT_CYC,
   parameter int          PG_WAIT_CYC   = `AMSC_PG_WAIT_CYC
)(
   input  wire logic        clock,
   input  wire logic        nrst,
   input  wire logic [7:0]  bus_addr,
   input  wire logic [31:0] bus_wdata,
   input  wire logic        bus_we,
   input  wire logic        bus_re,
   output var  logic [31:0] bus_rdata,
   input  wire amsc_pins_t  pins_in,
   output var  logic        eeprom_supply_en,
   output var  logic        adapter_supply_en,
   output var  logic        adapter_pins_en,
   output var  logic        pll_ref_onboard,
   output var  logic        fpga_shutdown,
   output var  logic        code_mismatch,
   output var  logic        pll_lost_lock
);

   // ==================================================
   // state registers
   amsc_regs_t q;
   amsc_regs_t d;

   localparam logic [19:0] ID_SETTLE = 20'(`AMSC_ID_SETTLE_CYC);
   localparam logic [19:0] PG_WAIT   = 20'(PG_WAIT_CYC);
   localparam logic [25:0] TEMP_WAIT = 26'(TEMP_WAIT_CYC);
   localparam logic [2:0]  STAT_DIV  = 3'(`AMSC_STAT_DIV);

   // address match, used by read and write decode
   function automatic logic amsc_hit(input logic [7:0] a, input logic [7:0] ofs);
      amsc_hit = (a == ofs);
   endfunction

   // ==================================================
   // combinational next state
   logic [16:0] rail_sum;
   logic [31:0] status_word;
   logic        stat_en;
   logic        removed;

   always_comb begin
      d = q;

      // two-flop synchronisers on all pin inputs
      d.sync1 = pins_in;
      d.sync2 = q.sync1;

      // 40 MHz rate enable from a divider
      stat_en = (q.div_cnt == STAT_DIV - 3'h1);
      d.div_cnt = stat_en ? 3'h0 : q.div_cnt + 3'h1;

      // status snapshot for the host view
      if (stat_en) begin
         d.snap = q.sync2;
      end

      // temperature settle window after reset
      if (!q.temp_ready) begin
         if (q.temp_cnt == TEMP_WAIT - 26'h1) begin
            d.temp_ready = 1'b1;
         end else begin
            d.temp_cnt = q.temp_cnt + 26'h1;
         end
      end

      // pll watch: sticky loss, fall back to onboard
      if (q.state != AMSC_BOOT) begin
         if (q.sync2.pll_locked) begin
            d.was_locked = 1'b1;
         end else if (q.was_locked) begin
            d.lost_lock = 1'b1;
            d.pll_onboard = 1'b1;
            d.was_locked = 1'b0;
         end
      end

      // rail power limits, shutdown held until reset
      rail_sum = {1'b0, q.sync2.low_power} + {1'b0, q.sync2.high_power};
      if ({1'b0, q.sync2.low_power} > `AMSC_LOW_LIMIT ||
          {1'b0, q.sync2.high_power} > `AMSC_HIGH_LIMIT ||
          rail_sum > `AMSC_SUM_LIMIT) begin
         d.shutdown = 1'b1;
      end

      // control register writes
      d.redetect = 1'b0;
      if (bus_we && amsc_hit(bus_addr, `AMSC_CTRL_OFS)) begin
         // power command ignored while nothing is inserted
         if (q.sync2.present) begin
            d.pwr_req = bus_wdata[`AMSC_CTRL_PWR_ON];
            d.redetect = bus_wdata[`AMSC_CTRL_REDETECT];
         end
      end

      // ==================================================
      // adapter sequencer
      removed = !q.sync2.present;
      unique case (q.state)
         AMSC_BOOT: begin
            // let synchronisers fill, then pick pll reference
            d.boot_cnt = q.boot_cnt + 3'h1;
            if (q.boot_cnt == 3'h3) begin
               d.pll_onboard = !q.sync2.ref_present;
               d.state = AMSC_ABSENT;
            end
         end
         AMSC_ABSENT: begin
            d.eeprom_en = 1'b0;
            d.supply_en = 1'b0;
            d.pins_en = 1'b0;
            d.mismatch = 1'b0;
            if (q.sync2.present) begin
               d.eeprom_en = 1'b1;
               d.wait_cnt = 20'h0;
               d.state = AMSC_READ_ID;
            end
         end
         AMSC_READ_ID: begin
            // eeprom powered, wait for the code to settle
            d.supply_en = 1'b0;
            d.pins_en = 1'b0;
            if (q.wait_cnt == ID_SETTLE - 20'h1) begin
               d.fit_code = q.sync2.fit_code;
               d.wait_cnt = 20'h0;
               if (q.sync2.fit_code != REQ_CODE) begin
                  d.mismatch = 1'b1;
                  d.state = AMSC_MISMATCH;
               end else begin
                  d.mismatch = 1'b0;
                  d.state = q.pwr_req ? AMSC_PWR_UP : AMSC_OFF;
               end
            end else begin
               d.wait_cnt = q.wait_cnt + 20'h1;
            end
         end
         AMSC_PWR_UP: begin
            d.supply_en = 1'b1;
            d.pins_en = 1'b0;
            d.wait_cnt = q.wait_cnt + 20'h1;
            if (q.sync2.pgood) begin
               d.state = AMSC_RUN;
            end else if (q.wait_cnt == PG_WAIT - 20'h1) begin
               d.pg_timeout = 1'b1;
               d.supply_en = 1'b0;
               d.state = AMSC_PG_FAULT;
            end
         end
         AMSC_RUN: begin
            // pins only with rails good
            d.pins_en = q.sync2.pgood;
            if (!q.sync2.pgood) begin
               d.wait_cnt = 20'h0;
               d.state = AMSC_PWR_UP;
            end
         end
         AMSC_OFF: begin
            d.supply_en = 1'b0;
            d.pins_en = 1'b0;
            if (q.pwr_req) begin
               d.wait_cnt = 20'h0;
               d.pg_timeout = 1'b0;
               d.state = AMSC_PWR_UP;
            end
         end
         AMSC_MISMATCH: begin
            d.supply_en = 1'b0;
            d.pins_en = 1'b0;
         end
         AMSC_PG_FAULT: begin
            d.supply_en = 1'b0;
            d.pins_en = 1'b0;
            if (!q.pwr_req) begin
               d.state = AMSC_OFF;
            end
         end
         default: begin
            d.state = AMSC_ABSENT;
         end
      endcase

      // turning power off from any powered state
      if (!q.pwr_req && (q.state == AMSC_PWR_UP || q.state == AMSC_RUN)) begin
         d.supply_en = 1'b0;
         d.pins_en = 1'b0;
         d.state = AMSC_OFF;
      end

      // host asks to read the code again
      if (q.redetect && q.state != AMSC_BOOT && !removed) begin
         d.supply_en = 1'b0;
         d.pins_en = 1'b0;
         d.eeprom_en = 1'b1;
         d.wait_cnt = 20'h0;
         d.pg_timeout = 1'b0;
         d.state = AMSC_READ_ID;
      end

      // removal wins over everything else
      if (removed && q.state != AMSC_BOOT) begin
         d.eeprom_en = 1'b0;
         d.supply_en = 1'b0;
         d.pins_en = 1'b0;
         d.mismatch = 1'b0;
         d.pg_timeout = 1'b0;
         d.state = AMSC_ABSENT;
      end

      // ==================================================
      // register reads, answer one cycle later
      status_word = 32'h0;
      status_word[`AMSC_ST_PRESENT] = q.snap.present;
      status_word[`AMSC_ST_PGOOD] = q.snap.pgood;
      status_word[`AMSC_ST_EEPROM_EN] = q.eeprom_en;
      status_word[`AMSC_ST_SUPPLY_EN] = q.supply_en;
      status_word[`AMSC_ST_PINS_EN] = q.pins_en;
      status_word[`AMSC_ST_MISMATCH] = q.mismatch;
      status_word[`AMSC_ST_LOST_LOCK] = q.lost_lock;
      status_word[`AMSC_ST_PLL_ONBOARD] = q.pll_onboard;
      status_word[`AMSC_ST_TEMP_READY] = q.temp_ready;
      status_word[`AMSC_ST_SHUTDOWN] = q.shutdown;
      status_word[`AMSC_ST_PG_TIMEOUT] = q.pg_timeout;

      d.rdata = 32'h0;
      if (bus_re) begin
         if (amsc_hit(bus_addr, `AMSC_REQ_CODE_OFS)) begin
            d.rdata = REQ_CODE;
         end else if (amsc_hit(bus_addr, `AMSC_FIT_CODE_OFS)) begin
            d.rdata = q.fit_code;
         end else if (amsc_hit(bus_addr, `AMSC_STATUS_OFS)) begin
            d.rdata = status_word;
         end else if (amsc_hit(bus_addr, `AMSC_CTRL_OFS)) begin
            d.rdata = {31'h0, q.pwr_req};
         end else if (amsc_hit(bus_addr, `AMSC_TEMP_OFS)) begin
            d.rdata = {24'h0, q.snap.temp};
         end else if (amsc_hit(bus_addr, `AMSC_POWER_OFS)) begin
            d.rdata = {q.snap.high_power, q.snap.low_power};
         end
      end
   end

   // ==================================================
   // register the whole state, synchronous reset
   always_ff @(posedge clock) begin
      if (!nrst) begin
         q <= '0;
         q.state <= AMSC_BOOT;
         q.pwr_req <= `AMSC_CTRL_RESET;
      end else begin
         q <= d;
      end
   end

   // ==================================================
   // outputs straight from flops
   assign bus_rdata         = q.rdata;
   assign eeprom_supply_en  = q.eeprom_en;
   assign adapter_supply_en = q.supply_en;
   assign adapter_pins_en   = q.pins_en;
   assign pll_ref_onboard   = q.pll_onboard;
   assign fpga_shutdown     = q.shutdown;
   assign code_mismatch     = q.mismatch;
   assign pll_lost_lock     = q.lost_lock;

endmodule
`default_nettype wire

// [hw/amsc_regs.svh]
// Purpose: offsets, fields, reset values and timing counts of the adapter status block
// Assumes: 250 MHz clock, byte-addressed word registers
// Notes:   every offset, field and limit the block uses lives here
`ifndef AMSC_REGS_SVH
`define AMSC_REGS_SVH

// ==================================================
// timing
`define AMSC_CLK_MHZ        250
`define AMSC_STAT_MHZ       40
`define AMSC_STAT_DIV       (`AMSC_CLK_MHZ / `AMSC_STAT_MHZ)
`define AMSC_TEMP_WAIT_MS   250
`define AMSC_TEMP_WAIT_CYC  (`AMSC_TEMP_WAIT_MS * `AMSC_CLK_MHZ * 1000)
`define AMSC_ID_SETTLE_NS   1000
`define AMSC_ID_SETTLE_CYC  ((`AMSC_ID_SETTLE_NS * `AMSC_CLK_MHZ + 999) / 1000)
`define AMSC_PG_WAIT_US     100
`define AMSC_PG_WAIT_CYC    (`AMSC_PG_WAIT_US * `AMSC_CLK_MHZ)

// ==================================================
// register offsets (byte addresses)
`define AMSC_REQ_CODE_OFS   8'h00
`define AMSC_FIT_CODE_OFS   8'h04
`define AMSC_STATUS_OFS     8'h08
`define AMSC_CTRL_OFS       8'h0C
`define AMSC_TEMP_OFS       8'h10
`define AMSC_POWER_OFS      8'h14

// ==================================================
// status fields
`define AMSC_ST_PRESENT     0
`define AMSC_ST_PGOOD       1
`define AMSC_ST_EEPROM_EN   2
`define AMSC_ST_SUPPLY_EN   3
`define AMSC_ST_PINS_EN     4
`define AMSC_ST_MISMATCH    5
`define AMSC_ST_LOST_LOCK   6
`define AMSC_ST_PLL_ONBOARD 7
`define AMSC_ST_TEMP_READY  8
`define AMSC_ST_SHUTDOWN    9
`define AMSC_ST_PG_TIMEOUT  10

// control fields and reset values
`define AMSC_CTRL_PWR_ON    0
`define AMSC_CTRL_REDETECT  1
`define AMSC_CTRL_RESET     1'h1

// ==================================================
// rail limits in 10 mW counts
`define AMSC_LOW_LIMIT      17'h003CA
`define AMSC_HIGH_LIMIT     17'h00DDE
`define AMSC_SUM_LIMIT      17'h00EBF

// required adapter code, value arbitrary
`define AMSC_REQ_CODE_DEF   32'h0000_0A5C

`endif

// [hw/amsc_pkg.sv]
// Purpose: types of the adapter status block
// Assumes: nothing beyond SystemVerilog
// Notes:   constants live in amsc_regs.svh
`default_nettype none
package amsc_pkg;

   // pin inputs from the carrier board
   typedef struct packed {
      logic        present;
      logic        pgood;
      logic        pll_locked;
      logic        ref_present;
      logic [31:0] fit_code;
      logic [7:0]  temp;
      logic [15:0] low_power;
      logic [15:0] high_power;
   } amsc_pins_t;

   // adapter sequencer states
   typedef enum logic [7:0] {
      AMSC_BOOT     = 8'h01,
      AMSC_ABSENT   = 8'h02,
      AMSC_READ_ID  = 8'h04,
      AMSC_PWR_UP   = 8'h08,
      AMSC_RUN      = 8'h10,
      AMSC_OFF      = 8'h20,
      AMSC_MISMATCH = 8'h40,
      AMSC_PG_FAULT = 8'h80
   } amsc_state_t;

   // whole state of the top module
   typedef struct packed {
      amsc_pins_t  sync1;
      amsc_pins_t  sync2;
      amsc_pins_t  snap;
      amsc_state_t state;
      logic [2:0]  boot_cnt;
      logic [2:0]  div_cnt;
      logic [19:0] wait_cnt;
      logic [25:0] temp_cnt;
      logic        temp_ready;
      logic [31:0] fit_code;
      logic        mismatch;
      logic        eeprom_en;
      logic        supply_en;
      logic        pins_en;
      logic        pwr_req;
      logic        redetect;
      logic        was_locked;
      logic        lost_lock;
      logic        pll_onboard;
      logic        shutdown;
      logic        pg_timeout;
      logic [31:0] rdata;
   } amsc_regs_t;

endpackage
`default_nettype wire

// [verif/amsc_checker.sv]
// Purpose: concurrent checks on the adapter status block ports
// Assumes: one clock, synchronous active-low reset
// Notes:   bound to every instance of the top module
`timescale 1ns/1ps
`default_nettype none
`include "amsc_regs.svh"

module amsc_checker
   import amsc_pkg::*;
#(
   parameter logic [31:0] REQ_CODE = `AMSC_REQ_CODE_DEF
)(
   input wire logic        clock,
   input wire logic        nrst,
   input wire logic [7:0]  bus_addr,
   input wire logic        bus_re,
   input wire logic [31:0] bus_rdata,
   input wire amsc_pins_t  pins_in,
   input wire logic        eeprom_supply_en,
   input wire logic        adapter_supply_en,
   input wire logic        adapter_pins_en,
   input wire logic        pll_ref_onboard,
   input wire logic        fpga_shutdown,
   input wire logic        code_mismatch,
   input wire logic        pll_lost_lock
);
   // ==================================================
   // helpers
   logic over;
   // some rail or the sum above its limit
   assign over = ({1'b0, pins_in.low_power} > `AMSC_LOW_LIMIT)
      || ({1'b0, pins_in.high_power} > `AMSC_HIGH_LIMIT)
      || ({1'b0, pins_in.low_power} + {1'b0, pins_in.high_power} > `AMSC_SUM_LIMIT);

   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);

   // ==================================================
   // assertions
   AST_SUPPLY_CODE: assert property ($rose(adapter_supply_en) |->
      pins_in.fit_code == REQ_CODE) else $error("supply on with foreign code");
   AST_MISMATCH_OFF: assert property (code_mismatch |->
      !adapter_supply_en && !adapter_pins_en) else $error("mismatch with power on");
   AST_PINS_SUPPLY: assert property (adapter_pins_en |-> adapter_supply_en)
      else $error("pins on without supply");
   AST_PINS_PGOOD: assert property ($rose(adapter_pins_en) |->
      $past(pins_in.pgood, 3) && pins_in.pgood) else $error("pins on before power good");
   AST_REMOVAL: assert property (!pins_in.present [*5] |->
      !eeprom_supply_en && !adapter_supply_en && !adapter_pins_en)
      else $error("enables stay after removal");
   AST_LOST_SET: assert property (pins_in.pll_locked [*6] ##1 !pins_in.pll_locked [*2] |->
      ##[1:4] (pll_lost_lock && pll_ref_onboard)) else $error("lock loss not flagged");
   AST_LOST_HOLD: assert property (pll_lost_lock |=> pll_lost_lock)
      else $error("lost lock flag cleared");
   AST_SHUT_SET: assert property (over [*3] |-> ##[0:6] fpga_shutdown)
      else $error("no shutdown over limit");
   AST_SHUT_CAUSE: assert property ($rose(fpga_shutdown) |->
      $past(over, 2) || $past(over, 3) || $past(over, 4)) else $error("shutdown without cause");
   AST_REQ_READ: assert property ($past(bus_re) && $past(bus_addr) == `AMSC_REQ_CODE_OFS |->
      bus_rdata == REQ_CODE) else $error("wrong required code");

   // main scenarios reached
   COV_PINS: cover property ($rose(adapter_pins_en));
   COV_MISMATCH: cover property ($rose(code_mismatch));
   COV_LOST: cover property ($rose(pll_lost_lock));
   COV_SHUT: cover property ($rose(fpga_shutdown));
endmodule

bind amsc_top amsc_checker #(.REQ_CODE(REQ_CODE)) u_amsc_checker (
   .clock(clock), .nrst(nrst), .bus_addr(bus_addr), .bus_re(bus_re),
   .bus_rdata(bus_rdata), .pins_in(pins_in), .eeprom_supply_en(eeprom_supply_en),
   .adapter_supply_en(adapter_supply_en), .adapter_pins_en(adapter_pins_en),
   .pll_ref_onboard(pll_ref_onboard), .fpga_shutdown(fpga_shutdown),
   .code_mismatch(code_mismatch), .pll_lost_lock(pll_lost_lock)
);
`default_nettype wire

// [verif/amsc_adapter_model.sv]
// Purpose: plug-in adapter on the connector
// Assumes: power good follows supply after pg_delay cycles
// Notes:   id lines toggle while the id eeprom is unpowered
`timescale 1ns/1ps
`default_nettype none

module amsc_adapter_model (
   input  wire logic        clock,
   input  wire logic        insert,
   input  wire logic [31:0] code,
   input  wire logic [7:0]  pg_delay,
   input  wire logic        eeprom_en,
   input  wire logic        supply_en,
   output var  logic        present,
   output var  logic        pgood,
   output var  logic [31:0] fit_code
);
   logic [7:0] pg_cnt;

   // quiet start
   initial begin
      present = 1'b0;
      pgood = 1'b0;
      fit_code = 32'h0;
      pg_cnt = 8'h0;
   end

   // attach, rail start-up and id lines
   always @(posedge clock) begin
      present <= insert;
      if (!supply_en) begin
         pg_cnt <= 8'h0;
         pgood <= 1'b0;
      end else if (pg_cnt < pg_delay) begin
         pg_cnt <= pg_cnt + 8'h01;
      end else begin
         pgood <= 1'b1;
      end
      fit_code <= (present && eeprom_en) ? code : ~fit_code;
   end
endmodule
`default_nettype wire

// [verif/testbench.sv]
// Purpose: self-checking bench of the adapter status block
// Assumes: 250 MHz clock, shortened wait counts
// Notes:   read results are checked from a queue of expectations
`timescale 1ns/1ps
`default_nettype none
`include "amsc_regs.svh"

module testbench
   import amsc_pkg::*;
;
   typedef struct packed {logic [31:0] v; logic [31:0] m;} amsc_exp_t;
   localparam logic [31:0] REQ = `AMSC_REQ_CODE_DEF;

   logic        clock = 1'b0, nrst = 1'b0, bus_we = 1'b0, bus_re = 1'b0, re_d = 1'b0;
   logic [7:0]  bus_addr = 8'h0, temp = 8'h0, pgd = 8'h1E;
   logic [31:0] bus_wdata = 32'h0, bus_rdata, code = 32'h0, m_code, rnd = 32'h44BC5E86;
   logic        lock = 1'b1, refp = 1'b1, ins = 1'b0, m_pres, m_pg;
   logic [15:0] lowp = 16'h0, highp = 16'h0;
   logic        eep, sup, pen, onb, shut, mis, lost;
   logic [6:0]  outs;
   amsc_pins_t  pins;
   amsc_exp_t   exp_q[$];
   amsc_exp_t   e_now;
   int          bad_count = 0, samples_checked = 0;
   logic [15:0] lo [4] = '{16'h03CB, 16'h0000, 16'h03CA, 16'h03CA};
   logic [15:0] hi [4] = '{16'h0000, 16'h0DDF, 16'h0AF6, 16'h0AF5};
   logic        trip [4] = '{1'b1, 1'b1, 1'b1, 1'b0};

   // clock and pin bundle
   always #2 clock = ~clock;
   assign pins = {m_pres, m_pg, lock, refp, m_code, temp, lowp, highp};
   assign outs = {lost, mis, shut, onb, pen, sup, eep};

   amsc_top #(.REQ_CODE(REQ), .TEMP_WAIT_CYC(100), .PG_WAIT_CYC(50)) u_amsc_top (
      .clock(clock), .nrst(nrst), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
      .bus_we(bus_we), .bus_re(bus_re), .bus_rdata(bus_rdata), .pins_in(pins),
      .eeprom_supply_en(eep), .adapter_supply_en(sup), .adapter_pins_en(pen),
      .pll_ref_onboard(onb), .fpga_shutdown(shut), .code_mismatch(mis), .pll_lost_lock(lost));
   amsc_adapter_model u_amsc_adapter_model (
      .clock(clock), .insert(ins), .code(code), .pg_delay(pgd), .eeprom_en(eep),
      .supply_en(sup), .present(m_pres), .pgood(m_pg), .fit_code(m_code));

   // ==================================================
   // helpers
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] want);
      samples_checked++;
      if (got !== want) begin
         bad_count++;
         $display("Error at %0t: got %h want %h", $time, got, want);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      bus_we <= 1'b1;
      bus_addr <= a;
      bus_wdata <= d;
      @(posedge clock);
      bus_we <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] v, input logic [31:0] m);
      @(posedge clock);
      bus_re <= 1'b1;
      bus_addr <= a;
      exp_q.push_back('{v, m});
      @(posedge clock);
      bus_re <= 1'b0;
   endtask

   task automatic wait_bit(input int b, input logic v, input int n);
      int i;
      i = 0;
      while (outs[b] !== v && i < n) begin
         @(negedge clock);
         i++;
      end
      chk({31'h0, outs[b]}, {31'h0, v});
   endtask

   task automatic close_out;
      $display("checked %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   // read data compared mid-cycle, one cycle after each read strobe
   always @(negedge clock) begin
      if (re_d) begin
         e_now = exp_q.pop_front();
         chk(bus_rdata & e_now.m, e_now.v & e_now.m);
      end
      re_d <= bus_re;
   end

   // hang guard
   initial begin
      #80000;
      bad_count++;
      $display("Error at %0t: watchdog", $time);
      close_out();
   end

   // ==================================================
   // scenarios
   initial begin
      repeat (5) @(posedge clock);
      nrst <= 1'b1;
      repeat (10) @(negedge clock);
      chk({25'h0, outs}, 32'h0);
      rd(`AMSC_REQ_CODE_OFS, REQ, 32'hFFFFFFFF);
      rd(8'h1C, 32'h0, 32'hFFFFFFFF);
      rd(`AMSC_STATUS_OFS, 32'h0, 32'h0000003F);
      wr(`AMSC_CTRL_OFS, 32'h0);
      $display("test absent done");
      rnd = lfsr(rnd);
      @(posedge clock);
      temp <= rnd[7:0];
      lowp <= {7'h0, rnd[16:8]};
      highp <= {5'h0, rnd[27:17]};
      code <= REQ;
      ins <= 1'b1;
      wait_bit(2, 1'b1, 600);
      chk({25'h0, outs}, 32'h7);
      repeat (6) @(negedge clock); // let the status snapshot catch up
      rd(`AMSC_FIT_CODE_OFS, REQ, 32'hFFFFFFFF);
      rd(`AMSC_STATUS_OFS, 32'h0000011F, 32'h000003FF);
      rd(`AMSC_TEMP_OFS, {24'h0, temp}, 32'h000000FF);
      rd(`AMSC_POWER_OFS, {highp, lowp}, 32'hFFFFFFFF);
      $display("test power up done");
      wr(`AMSC_CTRL_OFS, 32'h0);
      wait_bit(1, 1'b0, 20);
      chk({31'h0, pen}, 32'h0);
      pgd <= 8'h03;
      wr(`AMSC_CTRL_OFS, 32'h1);
      wait_bit(2, 1'b1, 400);
      $display("test host power done");
      pgd <= 8'hFF;
      wr(`AMSC_CTRL_OFS, 32'h0);
      wr(`AMSC_CTRL_OFS, 32'h1);
      repeat (70) @(negedge clock);
      chk({31'h0, sup}, 32'h0);
      rd(`AMSC_STATUS_OFS, 32'h00000400, 32'h0000041A);
      $display("test power good timeout done");
      @(posedge clock);
      ins <= 1'b0;
      wait_bit(0, 1'b0, 20);
      chk({25'h0, outs}, 32'h0);
      repeat (12) @(negedge clock);
      rd(`AMSC_STATUS_OFS, 32'h0, 32'h0000001F);
      $display("test removal done");
      rnd = lfsr(rnd);
      @(posedge clock);
      code <= REQ ^ (rnd | 32'h1);
      ins <= 1'b1;
      wait_bit(5, 1'b1, 600);
      chk({30'h0, outs[2:1]}, 32'h0);
      rd(`AMSC_FIT_CODE_OFS, code, 32'hFFFFFFFF);
      rd(`AMSC_STATUS_OFS, 32'h00000021, 32'h00000039);
      code <= REQ;
      pgd <= 8'h03;
      wr(`AMSC_CTRL_OFS, 32'h3);
      wait_bit(2, 1'b1, 600);
      chk({31'h0, mis}, 32'h0);
      @(posedge clock);
      ins <= 1'b0;
      wait_bit(0, 1'b0, 20);
      $display("test mismatch done");
      @(posedge clock);
      lock <= 1'b0;
      repeat (4) @(posedge clock);
      lock <= 1'b1;
      wait_bit(6, 1'b1, 10);
      chk({30'h0, outs[6], outs[3]}, 32'h3);
      repeat (20) @(negedge clock);
      rd(`AMSC_STATUS_OFS, 32'h000000C0, 32'h000000C0);
      $display("test lock loss done");
      for (int k = 0; k < 4; k++) begin
         @(posedge clock);
         nrst <= 1'b0;
         lowp <= lo[k];
         highp <= hi[k];
         refp <= k[0];
         repeat (2) @(posedge clock);
         nrst <= 1'b1;
         repeat (20) @(negedge clock);
         chk({31'h0, shut}, {31'h0, trip[k]});
         chk({31'h0, lost}, 32'h0);
         chk({31'h0, onb}, {31'h0, ~k[0]});
      end
      $display("test rail limits done");
      close_out();
   end
endmodule
`default_nettype wire
